// File: verilog/icf_flag_unit.sv
// condition flags and arithmetic status register of the integer unit
`timescale 1ns/100ps
`include "icf_defines.svh"

module icf_flag_unit
    import icf_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [2:0] op_in,
    input wire logic wr_en_in,
    input wire logic [`ICF_AW-1:0] wr_addr_in,
    input wire logic [`ICF_XLEN-1:0] wr_data_in,
    input wire logic rec_in,
    input wire logic rec_own_in,
    input wire logic [`ICF_FLD_W-1:0] own_field_in,
    input wire logic ov_upd_in,
    input wire logic [`ICF_WIDE-1:0] res_wide_in,
    input wire logic res_signed_in,
    input wire logic ca_upd_in,
    input wire logic ca_val_in,
    input wire logic tbc_upd_in,
    input wire logic [`ICF_TBC_W-1:0] tbc_val_in,
    input wire logic [`ICF_XLEN-1:0] instr_in,
    input wire logic [`ICF_AW-1:0] src_a_in,
    input wire logic [`ICF_AW-1:0] src_b_in,
    input wire logic use_imm_in,
    input wire logic [`ICF_XLEN-1:0] imm_in,
    input wire logic [`ICF_AW-1:0] rd_addr_in,
    output logic [`ICF_XLEN-1:0] rd_data_out,
    output logic [`ICF_XLEN-1:0] cond_flags_out,
    output logic [`ICF_XLEN-1:0] status_out
);

    icf_state_t s_q;
    icf_state_t s_d;
    logic [`ICF_XLEN-1:0] opa_w;
    logic [`ICF_XLEN-1:0] opb_w;
    logic [`ICF_XLEN-1:0] calc_a;
    logic [`ICF_XLEN-1:0] calc_b;
    logic calc_signed;
    logic lt_w;
    logic gt_w;
    logic eq_w;
    logic ov_w;
    logic is_cmp_in;
    logic [`ICF_AW-1:0] port_b_addr;
    logic [`ICF_FLD_W-1:0] fld_w;
    logic [`ICF_AW-1:0] fld_pos;

    // a compare against a register borrows the user read port for a cycle
    assign is_cmp_in = (op_in == ICF_OP_CMPS) || (op_in == ICF_OP_CMPU);
    assign port_b_addr = (is_cmp_in && !use_imm_in) ? src_b_in
                                                    : rd_addr_in;

    icf_gpr_file #(
        .WIDTH(`ICF_XLEN),
        .DEPTH(`ICF_NREGS),
        .AW(`ICF_AW)
    ) u_gpr (
        .clk_sys_in(clk_sys_in),
        .wr_en_in(wr_en_in),
        .wr_addr_in(wr_addr_in),
        .wr_data_in(wr_data_in),
        .rd_a_addr_in(src_a_in),
        .rd_b_addr_in(port_b_addr),
        .rd_a_data_out(opa_w),
        .rd_b_data_out(opb_w)
    );

    icf_flag_calc #(
        .WIDTH(`ICF_XLEN)
    ) u_calc (
        .a_in(calc_a),
        .b_in(calc_b),
        .signed_in(calc_signed),
        .lt_out(lt_w),
        .gt_out(gt_w),
        .eq_out(eq_w)
    );

    // one shared comparator: record forms compare the result with zero
    always_comb
    begin
        calc_a = s_q.stg.res;
        calc_b = `ICF_ZERO32;
        calc_signed = 1'b1;
        if (s_q.stg.op == ICF_OP_CMPS || s_q.stg.op == ICF_OP_CMPU)
        begin
            calc_a = opa_w;
            calc_b = s_q.stg.use_imm ? s_q.stg.imm : opb_w;
            calc_signed = (s_q.stg.op == ICF_OP_CMPS);
        end
    end

    // overflow of the infinitely precise result
    always_comb
    begin
        if (s_q.stg.wide_signed)
        begin
            ov_w = !(&s_q.stg.wide[`ICF_WIDE-1:`ICF_XLEN-1]
                || !(|s_q.stg.wide[`ICF_WIDE-1:`ICF_XLEN-1]));
        end
        else
        begin
            ov_w = |s_q.stg.wide[`ICF_WIDE-1:`ICF_XLEN];
        end
    end

    always_comb
    begin
        s_d = s_q;
        fld_w = '0;
        fld_pos = '0;
        s_d.stg.op = icf_op_t'(op_in);
        s_d.stg.rec = rec_in;
        s_d.stg.own = rec_own_in;
        s_d.stg.own_fld = own_field_in;
        s_d.stg.ov_upd = ov_upd_in;
        s_d.stg.wide = res_wide_in;
        s_d.stg.wide_signed = res_signed_in;
        s_d.stg.ca_upd = ca_upd_in;
        s_d.stg.ca = ca_val_in;
        s_d.stg.tbc_upd = tbc_upd_in;
        s_d.stg.string_byte_count = tbc_val_in;
        s_d.stg.res = wr_data_in;
        s_d.stg.bf = instr_in[`ICF_BF_HI:`ICF_BF_LO];
        s_d.stg.use_imm = use_imm_in;
        s_d.stg.imm = imm_in;
        case (s_q.stg.op)
            ICF_OP_ARITH:
            begin
                if (s_q.stg.ca_upd)
                begin
                    s_d.spill = s_q.stg.ca;
                end
                if (s_q.stg.ov_upd)
                begin
                    s_d.ovf = ov_w;
                    s_d.sticky = s_q.sticky | ov_w;
                end
                if (s_q.stg.tbc_upd)
                begin
                    s_d.string_byte_count = s_q.stg.string_byte_count;
                end
                if (s_q.stg.rec)
                begin
                    if (s_q.stg.own)
                    begin
                        fld_w = s_q.stg.own_fld;
                    end
                    else
                    begin
                        fld_w[`ICF_FLD_LT] = lt_w;
                        fld_w[`ICF_FLD_GT] = gt_w;
                        fld_w[`ICF_FLD_EQ] = eq_w;
                        // without an overflow-recording form this is the
                        // old sticky value
                        fld_w[`ICF_FLD_SO] = s_d.sticky;
                    end
                    s_d.cond[`ICF_CR_MSB -: `ICF_FLD_W] = fld_w;
                end
            end
            ICF_OP_CMPS, ICF_OP_CMPU:
            begin
                fld_w[`ICF_FLD_LT] = lt_w;
                fld_w[`ICF_FLD_GT] = gt_w;
                fld_w[`ICF_FLD_EQ] = eq_w;
                fld_w[`ICF_FLD_SO] = s_q.sticky;
                fld_pos = {s_q.stg.bf, 2'b00};
                s_d.cond[`ICF_CR_MSB - fld_pos -: `ICF_FLD_W] = fld_w;
            end
            ICF_OP_MTS:
            begin
                // reserved source bits are dropped here
                s_d.sticky = opa_w[`ICF_ST_SO];
                s_d.ovf = opa_w[`ICF_ST_OV];
                s_d.spill = opa_w[`ICF_ST_CA];
                s_d.string_byte_count = opa_w[`ICF_ST_TBC_LSB +: `ICF_TBC_W];
            end
            ICF_OP_MCX:
            begin
                fld_w[`ICF_FLD_LT] = s_q.sticky;
                fld_w[`ICF_FLD_GT] = s_q.ovf;
                fld_w[`ICF_FLD_EQ] = s_q.spill;
                fld_w[`ICF_FLD_SO] = 1'b0;
                fld_pos = {s_q.stg.bf, 2'b00};
                s_d.cond[`ICF_CR_MSB - fld_pos -: `ICF_FLD_W] = fld_w;
                s_d.sticky = 1'b0;
                s_d.ovf = 1'b0;
                s_d.spill = 1'b0;
            end
            default:
            begin
                s_d.cond = s_q.cond;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign cond_flags_out = s_q.cond;
    // port b is registered in the file, so this output leaves a flip-flop
    assign rd_data_out = opb_w;
    assign status_out = {s_q.sticky, s_q.ovf, s_q.spill,
                         `ICF_ST_RSV_W'(0), s_q.string_byte_count};

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    logic rec_std;
    assign rec_std = (s_q.stg.op == ICF_OP_ARITH) && s_q.stg.rec
                     && !s_q.stg.own;

    AST_REC_LT: assert property (
        rec_std |=> s_q.cond[`ICF_CR_MSB] == $past(s_q.stg.res[31]))
        else $error("less-than flag does not follow result msb");

    AST_REC_GT: assert property (
        rec_std |=> s_q.cond[`ICF_CR_MSB-1] ==
            ($past(s_q.stg.res) != 0 && !$past(s_q.stg.res[31])))
        else $error("greater-than flag wrong for record");

    AST_REC_EQ: assert property (
        rec_std |=> s_q.cond[`ICF_CR_MSB-2] == ($past(s_q.stg.res) == 0))
        else $error("zero-match flag wrong for record");

    AST_REC_SO: assert property (
        rec_std |=> s_q.cond[`ICF_CR_MSB-3] == s_q.sticky)
        else $error("record bit 3 differs from sticky flag");

    AST_SO_NOFOLD: assert property (
        rec_std && !s_q.stg.ov_upd
        |=> s_q.cond[`ICF_CR_MSB-3] == $past(s_q.sticky))
        else $error("overflow folded into copy by non-recording form");

    AST_CMP_UNS: assert property (
        s_q.stg.op == ICF_OP_CMPU && calc_a == 0 && calc_b == '1
        |=> s_q.cond[`ICF_CR_MSB - {$past(s_q.stg.bf), 2'b00}])
        else $error("logical compare: zero not below all-ones");

    AST_MCX_CLR: assert property (
        s_q.stg.op == ICF_OP_MCX
        |=> !s_q.sticky && !s_q.ovf && !s_q.spill
            && s_q.cond[`ICF_CR_MSB - {$past(s_q.stg.bf), 2'b00}]
               == $past(s_q.sticky))
        else $error("status-to-condition copy wrong");

    AST_MTS_LOAD: assert property (
        s_q.stg.op == ICF_OP_MTS
        |=> s_q.string_byte_count == $past(opa_w[`ICF_TBC_W-1:0])
            && s_q.ovf == $past(opa_w[`ICF_ST_OV]))
        else $error("move did not load status fields");

    AST_STICKY_HOLD: assert property (
        s_q.sticky && s_q.stg.op != ICF_OP_MTS
        && s_q.stg.op != ICF_OP_MCX |=> s_q.sticky)
        else $error("sticky flag cleared without move or copy");

    AST_RSV_ZERO: assert property (
        status_out[`ICF_ST_RSV_HI:`ICF_ST_RSV_LO] == 0)
        else $error("reserved status bits not zero");

    AST_CMPU_FLD: assert property (
        s_q.stg.op == ICF_OP_CMPU
        |=> s_q.cond[`ICF_CR_MSB - {$past(s_q.stg.bf), 2'b00} -: `ICF_FLD_W]
            == {$past(calc_a) < $past(calc_b),
                $past(calc_a) > $past(calc_b),
                $past(calc_a) == $past(calc_b), $past(s_q.sticky)})
        else $error("logical compare field wrong");

    AST_CMPS_FLD: assert property (
        s_q.stg.op == ICF_OP_CMPS
        |=> s_q.cond[`ICF_CR_MSB - {$past(s_q.stg.bf), 2'b00} -: `ICF_FLD_W]
            == {$signed($past(calc_a)) < $signed($past(calc_b)),
                $signed($past(calc_a)) > $signed($past(calc_b)),
                $past(calc_a) == $past(calc_b), $past(s_q.sticky)})
        else $error("arithmetic compare field wrong");

    AST_OV_SGN: assert property (
        s_q.stg.op == ICF_OP_ARITH && s_q.stg.ov_upd && s_q.stg.wide_signed
        |=> s_q.ovf == !($past(s_q.stg.wide[`ICF_WIDE-1:`ICF_XLEN-1]) == '0
            || $past(s_q.stg.wide[`ICF_WIDE-1:`ICF_XLEN-1]) == '1))
        else $error("signed overflow flag wrong");

    AST_OV_UNS: assert property (
        s_q.stg.op == ICF_OP_ARITH && s_q.stg.ov_upd && !s_q.stg.wide_signed
        |=> s_q.ovf == ($past(s_q.stg.wide[`ICF_WIDE-1:`ICF_XLEN]) != '0))
        else $error("unsigned overflow flag wrong");

    AST_OV_HOLD: assert property (
        s_q.stg.op == ICF_OP_ARITH && !s_q.stg.ov_upd |=> $stable(s_q.ovf))
        else $error("overflow flag changed by non-recording form");

    AST_STICKY_SET: assert property (
        s_q.stg.op == ICF_OP_ARITH && s_q.stg.ov_upd
        |=> s_q.sticky == ($past(s_q.sticky) || s_q.ovf))
        else $error("sticky flag does not collect overflow");

    AST_SPILL: assert property (
        s_q.stg.op == ICF_OP_ARITH && s_q.stg.ca_upd
        |=> s_q.spill == $past(s_q.stg.ca))
        else $error("msb spill flag not written");

    AST_TBC: assert property (
        s_q.stg.op == ICF_OP_ARITH && s_q.stg.tbc_upd
        |=> s_q.string_byte_count == $past(s_q.stg.string_byte_count))
        else $error("byte count not written");

    AST_OWN_FLD: assert property (
        s_q.stg.op == ICF_OP_ARITH && s_q.stg.rec && s_q.stg.own
        |=> s_q.cond[`ICF_CR_MSB -: `ICF_FLD_W] == $past(s_q.stg.own_fld))
        else $error("excluded form did not supply its own field");

    AST_MCX_FLD: assert property (
        s_q.stg.op == ICF_OP_MCX
        |=> s_q.cond[`ICF_CR_MSB - {$past(s_q.stg.bf), 2'b00} -: `ICF_FLD_W]
            == {$past(s_q.sticky), $past(s_q.ovf), $past(s_q.spill), 1'b0})
        else $error("status-to-condition field wrong");

    AST_MTS_FLAGS: assert property (
        s_q.stg.op == ICF_OP_MTS |=> s_q.sticky == $past(opa_w[`ICF_ST_SO])
            && s_q.spill == $past(opa_w[`ICF_ST_CA]))
        else $error("move did not load sticky and spill flags");

    COV_REC_OV: cover property (rec_std && s_q.stg.ov_upd && ov_w);
    COV_CMPS: cover property (s_q.stg.op == ICF_OP_CMPS && lt_w);
    COV_MCX: cover property (s_q.stg.op == ICF_OP_MCX && s_q.sticky);
    COV_MTS: cover property (s_q.stg.op == ICF_OP_MTS);
    COV_CMPU: cover property (s_q.stg.op == ICF_OP_CMPU && lt_w);

endmodule

// File: verilog/icf_defines.svh
// constants for the integer condition flag update block
`ifndef ICF_DEFINES_SVH
`define ICF_DEFINES_SVH

`define ICF_XLEN 32
`define ICF_NREGS 32
`define ICF_AW 5
`define ICF_WIDE 64
`define ICF_TBC_W 7
// status register positions, bit 31 of the register is the msb
`define ICF_ST_SO 31
`define ICF_ST_OV 30
`define ICF_ST_CA 29
`define ICF_ST_RSV_HI 28
`define ICF_ST_RSV_LO 7
`define ICF_ST_RSV_W 22
`define ICF_ST_TBC_LSB 0
// target field select sits in instruction bits 6:8
`define ICF_BF_HI 25
`define ICF_BF_LO 23
`define ICF_BF_W 3
// nibble layout of one condition field
`define ICF_FLD_LT 3
`define ICF_FLD_GT 2
`define ICF_FLD_EQ 1
`define ICF_FLD_SO 0
`define ICF_FLD_W 4
`define ICF_CR_MSB 31
`define ICF_ZERO32 32'h0000_0000

`endif

// File: verilog/icf_pkg.sv
// types for the integer condition flag update block
`include "icf_defines.svh"

package icf_pkg;

    typedef enum logic [2:0] {
        ICF_OP_NONE = 3'h0,
        ICF_OP_ARITH = 3'h1,
        ICF_OP_CMPS = 3'h3,
        ICF_OP_CMPU = 3'h2,
        ICF_OP_MTS = 3'h6,
        ICF_OP_MCX = 3'h7
    } icf_op_t;

    typedef struct packed {
        icf_op_t op;
        logic rec;
        logic own;
        logic [`ICF_FLD_W-1:0] own_fld;
        logic ov_upd;
        logic [`ICF_WIDE-1:0] wide;
        logic wide_signed;
        logic ca_upd;
        logic ca;
        logic tbc_upd;
        logic [`ICF_TBC_W-1:0] string_byte_count;
        logic [`ICF_XLEN-1:0] res;
        logic [`ICF_BF_W-1:0] bf;
        logic use_imm;
        logic [`ICF_XLEN-1:0] imm;
    } icf_stage_t;

    typedef struct packed {
        icf_stage_t stg;
        logic [`ICF_XLEN-1:0] cond;
        logic sticky;
        logic ovf;
        logic spill;
        logic [`ICF_TBC_W-1:0] string_byte_count;
    } icf_state_t;

endpackage

// File: verilog/icf_gpr_file.sv
// general register file with one write and two registered read ports
`timescale 1ns/100ps
`include "icf_defines.svh"

module icf_gpr_file
    import icf_pkg::*;
#(
    parameter int WIDTH = `ICF_XLEN,
    parameter int DEPTH = `ICF_NREGS,
    parameter int AW = `ICF_AW
)
(
    input wire logic clk_sys_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic [AW-1:0] rd_a_addr_in,
    input wire logic [AW-1:0] rd_b_addr_in,
    output logic [WIDTH-1:0] rd_a_data_out,
    output logic [WIDTH-1:0] rd_b_data_out
);

    logic [WIDTH-1:0] mem_q [DEPTH];

    // no write-through: a read in the write cycle returns the old word
    always_ff @(posedge clk_sys_in)
    begin
        if (wr_en_in)
        begin
            mem_q[wr_addr_in] <= wr_data_in;
        end
        rd_a_data_out <= mem_q[rd_a_addr_in];
        rd_b_data_out <= mem_q[rd_b_addr_in];
    end

endmodule

// File: verilog/icf_flag_calc.sv
// less, greater and equal flags of a signed or unsigned compare
`timescale 1ns/100ps
`include "icf_defines.svh"

module icf_flag_calc
    import icf_pkg::*;
#(
    parameter int WIDTH = `ICF_XLEN
)
(
    input wire logic [WIDTH-1:0] a_in,
    input wire logic [WIDTH-1:0] b_in,
    input wire logic signed_in,
    output logic lt_out,
    output logic gt_out,
    output logic eq_out
);

    always_comb
    begin
        eq_out = (a_in == b_in);
        if (signed_in)
        begin
            lt_out = ($signed(a_in) < $signed(b_in));
        end
        else
        begin
            lt_out = (a_in < b_in);
        end
        gt_out = !lt_out && !eq_out;
    end

endmodule

// File: test/icf_pipe_model.sv
// pipeline and decoder model that issues operations to the flag unit
`timescale 1ns/100ps
`include "icf_defines.svh"

module icf_pipe_model
    import icf_pkg::*;
(
    input wire logic clk_sys_in,
    output icf_stage_t stg_out,
    output logic wen_out,
    output logic [`ICF_AW-1:0] waddr_out,
    output logic [`ICF_AW-1:0] sa_out,
    output logic [`ICF_AW-1:0] sb_out
);
    // one call puts one operation in front of exactly one sampling edge
    task automatic issue(input icf_stage_t s, input logic we,
        input logic [`ICF_AW-1:0] wa, input logic [`ICF_AW-1:0] a,
        input logic [`ICF_AW-1:0] b);
        @(negedge clk_sys_in);
        stg_out = s;
        wen_out = we;
        waddr_out = wa;
        sa_out = a;
        sb_out = b;
    endtask

    // released lines show the inverse so stale data cannot pass for good
    task automatic idle();
        icf_stage_t t;
        @(negedge clk_sys_in);
        t = ~stg_out;
        t.op = ICF_OP_NONE;
        stg_out = t;
        wen_out = 1'b0;
        sa_out = ~sa_out;
        sb_out = ~sb_out;
    endtask

    initial
    begin
        stg_out = '0;
        wen_out = 1'b0;
        waddr_out = '0;
        sa_out = '0;
        sb_out = '0;
    end
endmodule

// File: test/testbench.sv
// self-checking bench for the condition flag and status unit
`timescale 1ns/100ps
`include "icf_defines.svh"

module testbench
    import icf_pkg::*;
    ();
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic [`ICF_AW-1:0] rd_addr = '0;
    icf_stage_t stg;
    logic wen;
    logic [`ICF_AW-1:0] waddr, sa, sb;
    logic [31:0] rd_data, cond, status;
    logic [31:0] exp_cond = '0;
    int n_fail = 0;
    int n_compared = 0;

    initial
    begin
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end

    icf_pipe_model i_pipe (.clk_sys_in(clk_sys_in), .stg_out(stg),
        .wen_out(wen), .waddr_out(waddr), .sa_out(sa), .sb_out(sb));

    icf_flag_unit i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .op_in(stg.op), .wr_en_in(wen), .wr_addr_in(waddr),
        .wr_data_in(stg.res), .rec_in(stg.rec), .rec_own_in(stg.own),
        .own_field_in(stg.own_fld), .ov_upd_in(stg.ov_upd),
        .res_wide_in(stg.wide), .res_signed_in(stg.wide_signed),
        .ca_upd_in(stg.ca_upd), .ca_val_in(stg.ca),
        .tbc_upd_in(stg.tbc_upd), .tbc_val_in(stg.string_byte_count),
        .instr_in({6'h00, stg.bf, 23'h000000}), .src_a_in(sa),
        .src_b_in(sb), .use_imm_in(stg.use_imm), .imm_in(stg.imm),
        .rd_addr_in(rd_addr), .rd_data_out(rd_data),
        .cond_flags_out(cond), .status_out(status));

    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask

    function automatic icf_stage_t mk(input icf_op_t op,
        input logic [31:0] r);
        mk = '0;
        mk.op = op;
        mk.res = r;
        mk.wide = {{32{r[31]}}, r};
        mk.wide_signed = 1'b1;
    endfunction

    // result lands on the edge after the op is taken, checked at a low phase
    task automatic run(input icf_stage_t s, input logic [4:0] a,
        input logic [4:0] b);
        i_pipe.issue(s, 1'b0, 5'h00, a, b);
        i_pipe.idle();
        @(negedge clk_sys_in);
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        i_pipe.issue(mk(ICF_OP_NONE, d), 1'b1, a, 5'h00, 5'h00);
        i_pipe.idle();
    endtask

    task automatic test_compare();
        icf_stage_t s;
        logic [31:0] bv;
        logic [3:0] e;
        check("cond after reset", 32'h00000000, cond);
        check("status after reset", 32'h00000000, status);
        wr(5'h01, 32'h00000000);
        wr(5'h02, 32'hFFFFFFFF);
        wr(5'h03, 32'h00000000);
        rd_addr = 5'h02;
        @(negedge clk_sys_in);
        @(negedge clk_sys_in);
        check("register read", 32'hFFFFFFFF, rd_data);
        for (int f = 0; f < 8; f++)
        begin
            s = mk(f[0] ? ICF_OP_CMPS : ICF_OP_CMPU, 32'h00000000);
            s.bf = f[2:0];
            s.use_imm = f[1];
            bv = f[2] ? 32'h00000000 : 32'hFFFFFFFF;
            s.imm = bv;
            e = (bv == 32'h0) ? 4'h2 : (f[0] ? 4'h4 : 4'h8);
            exp_cond[31-4*f -: 4] = e;
            run(s, 5'h01, f[2] ? 5'h03 : 5'h02);
            check("compare fields", exp_cond, cond);
        end
        $display("test_compare done");
    endtask

    task automatic test_record();
        icf_stage_t s;
        logic [31:0] r [4] = '{32'h80000000, 32'h00000001, 32'h00000000,
            32'h7FFFFFFF};
        logic [3:0] e [4] = '{4'h8, 4'h4, 4'h2, 4'h4};
        for (int i = 0; i < 4; i++)
        begin
            s = mk(ICF_OP_ARITH, r[i]);
            s.rec = 1'b1;
            s.ov_upd = 1'b1;
            run(s, 5'h00, 5'h00);
            check("record field", e[i], cond[31:28]);
        end
        s = mk(ICF_OP_ARITH, 32'h00000000);
        s.rec = 1'b1;
        s.wide = 64'hFFFFFFFF_00000000;
        run(s, 5'h00, 5'h00);
        check("silent overflow field", 4'h2, cond[31:28]);
        check("silent overflow status", 32'h0, status);
        s.ov_upd = 1'b1;
        run(s, 5'h00, 5'h00);
        check("overflow field", 4'h3, cond[31:28]);
        check("overflow status", 32'hC0000000, status);
        s = mk(ICF_OP_ARITH, 32'h00000001);
        s.rec = 1'b1;
        s.ov_upd = 1'b1;
        run(s, 5'h00, 5'h00);
        check("sticky kept field", 4'h5, cond[31:28]);
        check("ov cleared status", 32'h80000000, status);
        s = mk(ICF_OP_ARITH, 32'hFFFFFFFF);
        s.rec = 1'b1;
        s.ov_upd = 1'b1;
        s.wide_signed = 1'b0;
        s.wide = 64'h00000000_FFFFFFFF;
        run(s, 5'h00, 5'h00);
        check("unsigned max field", 4'h9, cond[31:28]);
        check("unsigned max status", 32'h80000000, status);
        s.wide = 64'h00000001_00000000;
        s.res = 32'h00000000;
        run(s, 5'h00, 5'h00);
        check("unsigned over status", 32'hC0000000, status);
        s = mk(ICF_OP_ARITH, 32'h00000000);
        s.rec = 1'b1;
        s.own = 1'b1;
        s.own_fld = 4'hA;
        run(s, 5'h00, 5'h00);
        check("own form field", 4'hA, cond[31:28]);
        s = mk(ICF_OP_CMPS, 32'h00000000);
        s.bf = 3'h7;
        s.use_imm = 1'b1;
        run(s, 5'h01, 5'h00);
        check("compare sticky copy", 4'h3, cond[3:0]);
        $display("test_record done");
    endtask

    task automatic test_status();
        icf_stage_t s;
        wr(5'h06, 32'h1FFFFF80);
        run(mk(ICF_OP_MTS, 32'h0), 5'h06, 5'h00);
        check("reserved move", 32'h00000000, status);
        s = mk(ICF_OP_ARITH, 32'h0);
        s.ca_upd = 1'b1;
        s.ca = 1'b1;
        s.tbc_upd = 1'b1;
        s.string_byte_count = 7'h55;
        run(s, 5'h00, 5'h00);
        check("spill and count", 32'h20000055, status);
        s.ca = 1'b0;
        s.string_byte_count = 7'h2A;
        run(s, 5'h00, 5'h00);
        check("spill cleared", 32'h0000002A, status);
        run(mk(ICF_OP_MTS, 32'h0), 5'h02, 5'h00);
        check("full move", 32'hE000007F, status);
        // move then copy on consecutive edges: copy must see the move
        i_pipe.issue(mk(ICF_OP_MTS, 32'h0), 1'b0, 5'h00, 5'h02, 5'h00);
        i_pipe.issue(mk(ICF_OP_MCX, 32'h0), 1'b0, 5'h00, 5'h00, 5'h00);
        i_pipe.idle();
        @(negedge clk_sys_in);
        check("copy field", 4'hE, cond[31:28]);
        check("copy status", 32'h0000007F, status);
        $display("test_status done");
    endtask

    // a mid-run reset clears both registers at once, then work resumes
    task automatic test_reset();
        icf_stage_t s;
        @(negedge clk_sys_in);
        rst_in = 1'b1;
        #1;
        check("cond in reset", 32'h00000000, cond);
        check("status in reset", 32'h00000000, status);
        @(negedge clk_sys_in);
        rst_in = 1'b0;
        s = mk(ICF_OP_ARITH, 32'h80000000);
        s.rec = 1'b1;
        run(s, 5'h00, 5'h00);
        check("record after reset", 32'h80000000, cond);
        $display("test_reset done");
    endtask

    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (2000) @(posedge clk_sys_in);
        $display("MISMATCH watchdog expected done seen hang");
        n_fail++;
        tally_and_finish();
    end

    initial
    begin
        repeat (5) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        rst_in = 1'b0;
        test_compare();
        test_record();
        test_status();
        test_reset();
        tally_and_finish();
    end
endmodule
